// [core/ujfap_map.svh]
`ifndef UJFAP_MAP_SVH
`define UJFAP_MAP_SVH

// Register offsets on the plain register port
`define UJFAP_ADDR_W 8
`define UJFAP_OFF_CTRL 8'h00
`define UJFAP_OFF_STATUS 8'h04
`define UJFAP_OFF_IRSHIFT 8'h08

// Control register layout and reset value
`define UJFAP_CTRL_TDO_EN_BIT 0
`define UJFAP_CTRL_RESET 1'h1

// Instruction register
`define UJFAP_IR_W 8
`define UJFAP_IR_RESET 8'h00
`define UJFAP_IR_CAPTURE 8'h01
`define UJFAP_USER_CODE_LO 8'h10
`define UJFAP_USER_CODE_HI 8'h7f

// Status register field positions
`define UJFAP_STAT_IR_LSB 0
`define UJFAP_STAT_STATE_LSB 8
`define UJFAP_STAT_USER_BIT 12

`endif

// [core/ujfap_pkg.sv]
package ujfap_pkg;

    typedef enum logic [3:0] {
        ST_TLR       = 4'h0,
        ST_IDLE      = 4'h1,
        ST_SEL_DR    = 4'h2,
        ST_CAP_DR    = 4'h3,
        ST_SHIFT_DR  = 4'h4,
        ST_EXIT1_DR  = 4'h5,
        ST_PAUSE_DR  = 4'h6,
        ST_EXIT2_DR  = 4'h7,
        ST_UPDATE_DR = 4'h8,
        ST_SEL_IR    = 4'h9,
        ST_CAP_IR    = 4'ha,
        ST_SHIFT_IR  = 4'hb,
        ST_EXIT1_IR  = 4'hc,
        ST_PAUSE_IR  = 4'hd,
        ST_EXIT2_IR  = 4'he,
        ST_UPDATE_IR = 4'hf
    } ujfap_state_t;

endpackage : ujfap_pkg

// [core/ujfap_top.sv]
// Behaviour
// - An 8-bit user instruction vector mirrors the instruction register contents.
// - The user instruction vector changes only on entry into Update-IR or Test-Logic-Reset, where it clears.
// - Codes 16 to 127 are user codes, flagged to user logic for its own decoding.
// - User serial in and data clock follow the test pins TDI and TCK; TDO takes user serial out on falling TCK outside Shift-IR.
// - Serial input carries data bits in Shift-DR and instruction bits in Shift-IR.
// - Shift, update and capture flags are high exactly in Shift-DR, Update-DR and Capture-DR.
`timescale 1ns/10ps
`include "ujfap_map.svh"
`default_nettype none

module ujfap_top (
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Test access pins
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic ntrst_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    // User logic side
    input wire logic user_serial_out_in,
    output logic [`UJFAP_IR_W-1:0] user_instr_vector_out,
    output logic user_code_out,
    output logic user_serial_in_out,
    output logic user_data_clock_out,
    output logic dr_shift_flag_out,
    output logic dr_update_flag_out,
    output logic dr_capture_flag_out,
    // Register port
    input wire logic [`UJFAP_ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out
);

    //----------------------------------------------------------------
    // Functions
    //----------------------------------------------------------------
    function automatic ujfap_pkg::ujfap_state_t tap_next(
        input ujfap_pkg::ujfap_state_t s,
        input logic tms
    );
        case (s)
            ujfap_pkg::ST_TLR:       tap_next = tms ? ujfap_pkg::ST_TLR : ujfap_pkg::ST_IDLE;
            ujfap_pkg::ST_IDLE:      tap_next = tms ? ujfap_pkg::ST_SEL_DR : ujfap_pkg::ST_IDLE;
            ujfap_pkg::ST_SEL_DR:    tap_next = tms ? ujfap_pkg::ST_SEL_IR : ujfap_pkg::ST_CAP_DR;
            ujfap_pkg::ST_CAP_DR: tap_next = tms ? ujfap_pkg::ST_EXIT1_DR :
                ujfap_pkg::ST_SHIFT_DR;
            ujfap_pkg::ST_SHIFT_DR: tap_next = tms ? ujfap_pkg::ST_EXIT1_DR :
                ujfap_pkg::ST_SHIFT_DR;
            ujfap_pkg::ST_EXIT1_DR: tap_next = tms ? ujfap_pkg::ST_UPDATE_DR :
                ujfap_pkg::ST_PAUSE_DR;
            ujfap_pkg::ST_PAUSE_DR: tap_next = tms ? ujfap_pkg::ST_EXIT2_DR :
                ujfap_pkg::ST_PAUSE_DR;
            ujfap_pkg::ST_EXIT2_DR: tap_next = tms ? ujfap_pkg::ST_UPDATE_DR :
                ujfap_pkg::ST_SHIFT_DR;
            ujfap_pkg::ST_UPDATE_DR: tap_next = tms ? ujfap_pkg::ST_SEL_DR : ujfap_pkg::ST_IDLE;
            ujfap_pkg::ST_SEL_IR:    tap_next = tms ? ujfap_pkg::ST_TLR : ujfap_pkg::ST_CAP_IR;
            ujfap_pkg::ST_CAP_IR: tap_next = tms ? ujfap_pkg::ST_EXIT1_IR :
                ujfap_pkg::ST_SHIFT_IR;
            ujfap_pkg::ST_SHIFT_IR: tap_next = tms ? ujfap_pkg::ST_EXIT1_IR :
                ujfap_pkg::ST_SHIFT_IR;
            ujfap_pkg::ST_EXIT1_IR: tap_next = tms ? ujfap_pkg::ST_UPDATE_IR :
                ujfap_pkg::ST_PAUSE_IR;
            ujfap_pkg::ST_PAUSE_IR: tap_next = tms ? ujfap_pkg::ST_EXIT2_IR :
                ujfap_pkg::ST_PAUSE_IR;
            ujfap_pkg::ST_EXIT2_IR: tap_next = tms ? ujfap_pkg::ST_UPDATE_IR :
                ujfap_pkg::ST_SHIFT_IR;
            ujfap_pkg::ST_UPDATE_IR: tap_next = tms ? ujfap_pkg::ST_SEL_DR : ujfap_pkg::ST_IDLE;
            default:                 tap_next = ujfap_pkg::ST_TLR;
        endcase
    endfunction : tap_next

    function automatic logic is_user_code(input logic [`UJFAP_IR_W-1:0] code);
        is_user_code = (code >= `UJFAP_USER_CODE_LO) && (code <= `UJFAP_USER_CODE_HI);
    endfunction : is_user_code

    //----------------------------------------------------------------
    // Pin synchronisers
    //----------------------------------------------------------------
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic tck_d_ff;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            tck_d_ff <= 1'h0;
        end else if (ce_in) begin
            pin_s1_ff <= {ntrst_in, tdi_in, tms_in, tck_in};
            pin_s2_ff <= pin_s1_ff;
            tck_d_ff <= pin_s2_ff[0];
        end
    end

    wire tck_s = pin_s2_ff[0];
    wire tms_s = pin_s2_ff[1];
    wire tdi_s = pin_s2_ff[2];
    wire trst_hit = ~pin_s2_ff[3];
    wire tck_rise = tck_s & ~tck_d_ff;
    wire tck_fall = ~tck_s & tck_d_ff;

    //----------------------------------------------------------------
    // Register port
    //----------------------------------------------------------------
    logic ctrl_tdo_en_ff;
    logic [31:0] rdata_ff;

    wire sel_ctrl = (reg_addr_in == `UJFAP_OFF_CTRL);
    wire sel_status = (reg_addr_in == `UJFAP_OFF_STATUS);
    wire sel_irshift = (reg_addr_in == `UJFAP_OFF_IRSHIFT);

    //----------------------------------------------------------------
    // Test access state machine
    //----------------------------------------------------------------
    ujfap_pkg::ujfap_state_t state_ff;
    ujfap_pkg::ujfap_state_t nxt_state;
    logic [`UJFAP_IR_W-1:0] ir_shift_ff;
    logic [`UJFAP_IR_W-1:0] nxt_ir_shift;
    logic [`UJFAP_IR_W-1:0] nxt_ir_vec;

    // Clock edges only move the machine; test reset forces logic reset
    assign nxt_state = trst_hit ? ujfap_pkg::ST_TLR :
                       tck_rise ? tap_next(state_ff, tms_s) : state_ff;

    wire enter_upd_ir = (nxt_state == ujfap_pkg::ST_UPDATE_IR) &&
                        (state_ff != ujfap_pkg::ST_UPDATE_IR);

    // Instruction bits shift in from TDI in Shift-IR
    assign nxt_ir_shift = (tck_rise && state_ff == ujfap_pkg::ST_CAP_IR) ? `UJFAP_IR_CAPTURE :
                          (tck_rise && state_ff == ujfap_pkg::ST_SHIFT_IR) ?
                          {tdi_s, ir_shift_ff[`UJFAP_IR_W-1:1]} : ir_shift_ff;

    assign nxt_ir_vec = (nxt_state == ujfap_pkg::ST_TLR) ? `UJFAP_IR_RESET :
                        enter_upd_ir ? ir_shift_ff : user_instr_vector_out;

    // Shift source: instruction bits in Shift-IR, user data in Shift-DR
    wire in_shift_ir = (state_ff == ujfap_pkg::ST_SHIFT_IR);
    wire in_shift_dr = (state_ff == ujfap_pkg::ST_SHIFT_DR);
    wire nxt_tdo = in_shift_ir ? ir_shift_ff[0] : user_serial_out_in;
    wire nxt_oe = in_shift_ir | (in_shift_dr & ctrl_tdo_en_ff);

    wire [31:0] status_word = ({24'h0, user_instr_vector_out} << `UJFAP_STAT_IR_LSB) |
                              ({28'h0, state_ff} << `UJFAP_STAT_STATE_LSB) |
                              ({31'h0, user_code_out} << `UJFAP_STAT_USER_BIT);
    wire [31:0] nxt_rdata = !reg_rd_in ? 32'h0 :
                            sel_ctrl ? {31'h0, ctrl_tdo_en_ff} :
                            sel_status ? status_word :
                            sel_irshift ? {24'h0, ir_shift_ff} : 32'h0;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_ff <= ujfap_pkg::ST_TLR;
            ir_shift_ff <= `UJFAP_IR_RESET;
            user_instr_vector_out <= `UJFAP_IR_RESET;
            user_code_out <= 1'h0;
        end else if (ce_in) begin
            state_ff <= nxt_state;
            ir_shift_ff <= nxt_ir_shift;
            user_instr_vector_out <= nxt_ir_vec;
            user_code_out <= is_user_code(nxt_ir_vec);
        end
    end

    // Flags registered from the next state so they track state_ff exactly
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            dr_shift_flag_out <= 1'h0;
            dr_update_flag_out <= 1'h0;
            dr_capture_flag_out <= 1'h0;
        end else if (ce_in) begin
            dr_shift_flag_out <= (nxt_state == ujfap_pkg::ST_SHIFT_DR);
            dr_update_flag_out <= (nxt_state == ujfap_pkg::ST_UPDATE_DR);
            dr_capture_flag_out <= (nxt_state == ujfap_pkg::ST_CAP_DR);
        end
    end

    // Pass-through of serial input and data clock; TDO changes on falling TCK
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            user_serial_in_out <= 1'h0;
            user_data_clock_out <= 1'h0;
            tdo_out <= 1'h0;
            tdo_oe_out <= 1'h0;
        end else if (ce_in) begin
            user_serial_in_out <= tdi_s;
            user_data_clock_out <= tck_s;
            if (tck_fall) begin
                tdo_out <= nxt_tdo;
                tdo_oe_out <= nxt_oe;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            ctrl_tdo_en_ff <= `UJFAP_CTRL_RESET;
            rdata_ff <= 32'h0;
        end else if (ce_in) begin
            if (reg_wr_in && sel_ctrl) begin
                ctrl_tdo_en_ff <= reg_wdata_in[`UJFAP_CTRL_TDO_EN_BIT];
            end
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_out = rdata_ff;

    //----------------------------------------------------------------
    // Assertions
    //----------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    AST_IR_ON_UPDATE: assert property (
        $changed(user_instr_vector_out) |->
            (state_ff == ujfap_pkg::ST_UPDATE_IR) || (state_ff == ujfap_pkg::ST_TLR))
        else $error("instruction vector changed outside Update-IR");
    AST_IR_MIRROR: assert property (
        $rose(state_ff == ujfap_pkg::ST_UPDATE_IR) |->
            user_instr_vector_out == $past(ir_shift_ff))
        else $error("instruction vector does not match shifted instruction");
    AST_USER_CODE: assert property (
        user_code_out == ((user_instr_vector_out >= `UJFAP_USER_CODE_LO) &&
            (user_instr_vector_out <= `UJFAP_USER_CODE_HI)))
        else $error("user code flag wrong");
    AST_SHIFT_FLAG: assert property (
        dr_shift_flag_out == (state_ff == ujfap_pkg::ST_SHIFT_DR))
        else $error("shift flag does not match state");
    AST_UPDATE_FLAG: assert property (
        dr_update_flag_out == (state_ff == ujfap_pkg::ST_UPDATE_DR))
        else $error("update flag does not match state");
    AST_CAPTURE_FLAG: assert property (
        $rose(dr_capture_flag_out) |-> $past(state_ff) == ujfap_pkg::ST_SEL_DR)
        else $error("capture flag raised from wrong state");
    AST_STATE_ON_EDGE: assert property (
        $changed(state_ff) |-> $past(tck_rise) || $past(trst_hit))
        else $error("state moved without a test clock edge");
    AST_SERIAL_IN: assert property (
        $past(ce_in) && $past(nrst_in) |-> user_serial_in_out == $past(tdi_s))
        else $error("serial input not passed through");
    AST_IR_SHIFT: assert property (
        tck_rise && ce_in && !trst_hit && state_ff == ujfap_pkg::ST_SHIFT_IR |=>
            ir_shift_ff[`UJFAP_IR_W-1] == $past(tdi_s))
        else $error("instruction bit not shifted from serial input");

    COV_DR_SCAN: cover property (dr_capture_flag_out ##[1:200] dr_update_flag_out);
    COV_USER_INSTR: cover property ($rose(user_code_out));
    COV_TDO_DRIVE: cover property ($rose(tdo_oe_out));

endmodule : ujfap_top

`default_nettype wire

// [bench/ujfap_jtag_model.sv]
`timescale 1ns/10ps
`default_nettype none

module ujfap_jtag_model (
    // Clock
    input wire logic clock_in,
    // Test pins
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    initial begin
        tck_out = 1'h0;
        tms_out = 1'h1;
        tdi_out = 1'h0;
    end

    // One test clock period of 80 ns; the test clock idles low between steps
    task automatic step(input logic tms, input logic tdi);
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (5) @(posedge clock_in);
        tck_out <= 1'h1;
        repeat (5) @(posedge clock_in);
        tck_out <= 1'h0;
        tdi_out <= ~tdi;
    endtask : step
endmodule : ujfap_jtag_model

`default_nettype wire

// [bench/ujfap_top_tb.sv]
`timescale 1ns/10ps
`include "ujfap_map.svh"
`default_nettype none

module ujfap_top_tb;
    logic clock_in, nrst_in, tck, tms, tdi, usr_out, wr, rd, ctrl;
    logic tdo, oe, code_o, usi, udc, fsh, fup, fcap;
    logic ntrst;
    bit tx_q[$];
    bit rx_q[$];
    logic [7:0] addr, lfsr, vec_o, ir, vec;
    logic [7:0] codes [5];
    logic [31:0] wdata, rdata, rd_val;
    logic [3:0] st;
    logic [63:0] nx [2] = '{64'h1bddbba146644311, 64'h2fefcc0287855920};
    int err_count = 0;
    int n_tests = 0;

    ujfap_top ujfap_top_inst (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(1'h1),
        .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .ntrst_in(ntrst), .tdo_out(tdo),
        .tdo_oe_out(oe), .user_serial_out_in(usr_out), .user_instr_vector_out(vec_o),
        .user_code_out(code_o), .user_serial_in_out(usi), .user_data_clock_out(udc),
        .dr_shift_flag_out(fsh), .dr_update_flag_out(fup), .dr_capture_flag_out(fcap),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata));

    ujfap_jtag_model ujfap_jtag_model_inst (.clock_in(clock_in), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi));

    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr_next

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        @(negedge clock_in);
        rd_val = rdata;
        @(posedge clock_in);
    endtask : reg_rd

    task automatic status_chk;
        reg_rd(`UJFAP_OFF_STATUS);
        check("status", rd_val, {19'h0, vec >= `UJFAP_USER_CODE_LO && vec <= `UJFAP_USER_CODE_HI,
            st, vec});
        reg_rd(`UJFAP_OFF_IRSHIFT);
        check("irshift", rd_val, {24'h0, ir});
    endtask : status_chk

    // ------------------------------------------------------------
    // One test clock step, mirrored in the reference state machine
    // ------------------------------------------------------------
    task automatic tap(input logic m, input logic d);
        logic was_shift;
        // User logic side: a raised shift flag marks the next TDI bit as stream data
        was_shift = fsh;
        if (st == ujfap_pkg::ST_SHIFT_DR) tx_q.push_back(d);
        if (st == ujfap_pkg::ST_SHIFT_IR) ir = {d, ir[7:1]};
        st = nx[m][st*4 +: 4];
        if (st == ujfap_pkg::ST_CAP_IR) ir = `UJFAP_IR_CAPTURE;
        if (st == ujfap_pkg::ST_UPDATE_IR) vec = ir;
        if (st == ujfap_pkg::ST_TLR) vec = `UJFAP_IR_RESET;
        ujfap_jtag_model_inst.step(m, d);
        @(negedge clock_in);
        check("vector", vec_o, vec);
        check("user_code", code_o, vec >= 8'h10 && vec <= 8'h7f);
        check("flags", {fsh, fup, fcap}, {st == ujfap_pkg::ST_SHIFT_DR,
            st == ujfap_pkg::ST_UPDATE_DR, st == ujfap_pkg::ST_CAP_DR});
        check("serial_in", usi, d);
        check("data_clock", udc, 1'b1);
        if (was_shift === 1'h1) rx_q.push_back(usi);
        if (fup === 1'h1) begin
            check("stream_len", rx_q.size(), tx_q.size());
            while (rx_q.size() > 0 && tx_q.size() > 0)
                check("stream_bit", rx_q.pop_front(), tx_q.pop_front());
            rx_q.delete();
            tx_q.delete();
        end
        if (st == ujfap_pkg::ST_SHIFT_IR || st == ujfap_pkg::ST_SHIFT_DR) begin
            repeat (4) @(negedge clock_in);
            check("tdo_oe", oe, st == ujfap_pkg::ST_SHIFT_IR || ctrl);
            if (st == ujfap_pkg::ST_SHIFT_IR || ctrl)
                check("tdo", tdo, st == ujfap_pkg::ST_SHIFT_IR ? ir[0] : usr_out);
        end
        @(posedge clock_in);
    endtask : tap

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    initial begin
        #200000;
        err_count++;
        wrap_up();
    end

    initial begin
        {nrst_in, usr_out, wr, rd, addr, wdata} = '0;
        ntrst = 1'h1;
        {st, ir, vec, ctrl, lfsr} = {4'h0, 8'h00, 8'h00, 1'b1, 8'h4a};
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        reg_rd(`UJFAP_OFF_CTRL);
        check("ctrl_reset", rd_val, 32'h1);
        reg_rd(8'h0c);
        check("unmapped", rd_val, 32'h0);
        reg_wr(`UJFAP_OFF_STATUS, 32'hffffffff);
        status_chk();
        codes = '{8'h0f, 8'h10, 8'h7f, 8'h80, lfsr_next(lfsr)};
        foreach (codes[k]) begin
            tap(1'b0, 1'b0);
            tap(1'b1, 1'b0);
            tap(1'b1, 1'b0);
            tap(1'b0, 1'b0);
            tap(1'b0, 1'b0);
            for (int i = 0; i < 8; i++) tap(i == 7, codes[k][i]);
            tap(1'b1, 1'b0);
            tap(1'b0, 1'b0);
            status_chk();
        end
        for (int c = 1; c >= 0; c--) begin
            reg_wr(`UJFAP_OFF_CTRL, c);
            ctrl = c[0];
            tap(1'b1, 1'b0);
            tap(1'b0, 1'b0);
            for (int i = 0; i < 5; i++) begin
                lfsr = lfsr_next(lfsr);
                usr_out <= lfsr[0];
                tap(i == 4, lfsr[1]);
            end
            tap(1'b1, 1'b0);
            tap(1'b0, 1'b0);
        end
        // Test reset pin: back to Test-Logic-Reset, vector cleared
        ntrst <= 1'h0;
        repeat (4) @(posedge clock_in);
        ntrst <= 1'h1;
        repeat (4) @(posedge clock_in);
        {st, vec} = {ujfap_pkg::ST_TLR, `UJFAP_IR_RESET};
        repeat (5) tap(1'b1, 1'b0);
        status_chk();
        // Second system reset in mid-run
        nrst_in <= 1'h0;
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'h1;
        {st, ir, vec, ctrl} = {ujfap_pkg::ST_TLR, `UJFAP_IR_RESET, `UJFAP_IR_RESET, 1'h1};
        reg_rd(`UJFAP_OFF_CTRL);
        check("ctrl_reset2", rd_val, 32'h1);
        status_chk();
        wrap_up();
    end
endmodule : ujfap_top_tb

`default_nettype wire
